// File: include/cacsc_pkg.sv
`default_nettype none
package cacsc_pkg;
  localparam int ANGLE_W = 9;
  localparam logic [ANGLE_W-1:0] ANGLE_MAX = 9'h167;
  localparam logic [ANGLE_W:0] FULL_TURN = 10'h168;
  localparam logic [ANGLE_W:0] TOP_DWELL = 10'h014;
  localparam logic [ANGLE_W-1:0] TOP_STOP_RESET = 9'h0d3;
  localparam logic [ANGLE_W-1:0] CARRY_LC_RESET = 9'h095;
  localparam logic [ANGLE_W-1:0] CARRY_STD_RESET = 9'h0aa;
  localparam logic [7:0] FAULT_SERIES = 8'h50;
  // overrun closure test start per switch 1/2 setting {sw1, sw2}
  localparam logic [ANGLE_W-1:0] TEST_START_11 = 9'h10e;
  localparam logic [ANGLE_W-1:0] TEST_START_10 = 9'h12c;
  localparam logic [ANGLE_W-1:0] TEST_START_01 = 9'h14a;
  localparam logic [ANGLE_W-1:0] TEST_START_00 = 9'h167;
  localparam int OPT_SW1 = 0;
  localparam int OPT_SW2 = 1;
  localparam int OPT_SW7 = 6;
  localparam int OPT_W = 8;
  localparam logic [1:0] CAPTURE_CYCLES = 2'h3;
  typedef enum logic [1:0] {
    CACSC_SEL_ANGLE_SPEED = 2'b00,
    CACSC_SEL_TOP_STOP = 2'b01,
    CACSC_SEL_CARRYUP = 2'b10
  } cacsc_sel_t;
endpackage
`default_nettype wire

// File: hw/cacsc_sync.sv
`default_nettype none
module cacsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb
  begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// File: hw/cacsc_top.sv
// Behaviour
// - top-stop window is on from top-stop angle through 19 further degrees (20 in all)
// - window and overrun sensor on together raise an 80-series fault
// - past carry-up angle the stroke completes despite palm release
// - carry-up works the same for a foot-started single stroke
// - carry-up default is 149 with light curtain, else 170
// - carry-up edits allowed only while option switch 7 is off
// - option switches are sampled once after power-up only
// - in inch mode select steps to the next setting indicator
// - key plus raises, key minus lowers the selected angle
// - settings are stored when selection returns to angle/speed
// - angle/speed shows crank angle and strokes per minute
// - switches 1 and 2 pick the overrun closure test start angle
`default_nettype none
module cacsc_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [8:0] crank_angle_i,
  input wire logic [9:0] speed_spm_i,
  input wire logic select_btn_i,
  input wire logic key_plus_i,
  input wire logic key_minus_i,
  input wire logic overrun_sensor_i,
  input wire logic palm_buttons_i,
  input wire logic foot_control_i,
  input wire logic inch_mode_i,
  input wire logic single_mode_i,
  input wire logic light_curtain_fw_i,
  input wire logic [7:0] option_switch_block_i,
  output logic top_stop_window_o,
  output logic overrun_fault_o,
  output logic [7:0] fault_code_o,
  output logic clutch_run_o,
  output logic carryup_passed_o,
  output logic overrun_test_active_o,
  output logic [1:0] display_sel_o,
  output logic [8:0] display_angle_o,
  output logic [9:0] display_spm_o,
  output logic commit_o,
  output logic [8:0] top_stop_angle_o,
  output logic [8:0] carryup_angle_o
);
  localparam int SW = 13 + cacsc_pkg::OPT_W - 8 + 4;

  logic [SW-1:0] raw_c;
  logic [SW-1:0] syn_c;
  logic sel_s, plus_s, minus_s, ovr_s, palm_s, foot_s, inch_s, single_s, lc_s;
  logic [cacsc_pkg::OPT_W-1:0] opt_s;

  assign raw_c = {select_btn_i, key_plus_i, key_minus_i, overrun_sensor_i,
                  palm_buttons_i, foot_control_i, inch_mode_i, single_mode_i,
                  light_curtain_fw_i, option_switch_block_i};

  cacsc_sync #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(raw_c),
    .q_o(syn_c)
  );

  assign {sel_s, plus_s, minus_s, ovr_s, palm_s, foot_s, inch_s, single_s,
          lc_s, opt_s} = syn_c;

  function automatic logic [8:0] ang_inc(input logic [8:0] v);
    ang_inc = (v == cacsc_pkg::ANGLE_MAX) ? 9'h000 : v + 9'h001;
  endfunction

  function automatic logic [8:0] ang_dec(input logic [8:0] v);
    ang_dec = (v == 9'h000) ? cacsc_pkg::ANGLE_MAX : v - 9'h001;
  endfunction

  logic [1:0] cap_cnt_reg, cap_cnt_next;
  logic opt_valid_reg, opt_valid_next;
  logic [cacsc_pkg::OPT_W-1:0] opt_reg, opt_next;
  logic sel_prev_reg, plus_prev_reg, minus_prev_reg;
  logic sel_prev_next, plus_prev_next, minus_prev_next;
  cacsc_pkg::cacsc_sel_t sel_reg, sel_next;
  logic [8:0] ts_work_reg, ts_work_next, ts_reg, ts_next;
  logic [8:0] cu_work_reg, cu_work_next, cu_reg, cu_next;
  logic win_reg, win_next, fault_reg, fault_next;
  logic [7:0] fault_code_reg, fault_code_next;
  logic active_reg, active_next, passed_reg, passed_next;
  logic run_reg, run_next, test_reg, test_next, commit_reg, commit_next;
  logic [8:0] disp_ang_reg, disp_ang_next;
  logic [9:0] disp_spm_reg, disp_spm_next;
  logic [9:0] diff_c;
  logic win_c, run_req_c, sel_rise_c, plus_rise_c, minus_rise_c;
  logic [8:0] test_ang_c;

  always_comb
  begin
    sel_rise_c = sel_s && !sel_prev_reg;
    plus_rise_c = plus_s && !plus_prev_reg;
    minus_rise_c = minus_s && !minus_prev_reg;
    if (crank_angle_i >= ts_reg)
      diff_c = {1'b0, crank_angle_i} - {1'b0, ts_reg};
    else
      diff_c = {1'b0, crank_angle_i} + cacsc_pkg::FULL_TURN - {1'b0, ts_reg};
    win_c = diff_c < cacsc_pkg::TOP_DWELL;
    run_req_c = palm_s || foot_s;
    case ({opt_reg[cacsc_pkg::OPT_SW1], opt_reg[cacsc_pkg::OPT_SW2]})
      2'b11: test_ang_c = cacsc_pkg::TEST_START_11;
      2'b10: test_ang_c = cacsc_pkg::TEST_START_10;
      2'b01: test_ang_c = cacsc_pkg::TEST_START_01;
      default: test_ang_c = cacsc_pkg::TEST_START_00;
    endcase

    cap_cnt_next = cap_cnt_reg;
    opt_valid_next = opt_valid_reg;
    opt_next = opt_reg;
    cu_next = cu_reg;
    cu_work_next = cu_work_reg;
    if (!opt_valid_reg)
    begin
      if (cap_cnt_reg == cacsc_pkg::CAPTURE_CYCLES)
      begin
        opt_valid_next = 1'b1;
        opt_next = opt_s;
        cu_next = lc_s ? cacsc_pkg::CARRY_LC_RESET
                       : cacsc_pkg::CARRY_STD_RESET;
        cu_work_next = cu_next;
      end
      else
        cap_cnt_next = cap_cnt_reg + 2'h1;
    end

    sel_prev_next = sel_s;
    plus_prev_next = plus_s;
    minus_prev_next = minus_s;
    sel_next = sel_reg;
    ts_work_next = ts_work_reg;
    ts_next = ts_reg;
    commit_next = 1'b0;
    if (inch_s && opt_valid_reg)
    begin
      if (sel_rise_c)
      begin
        case (sel_reg)
          cacsc_pkg::CACSC_SEL_ANGLE_SPEED:
            sel_next = cacsc_pkg::CACSC_SEL_TOP_STOP;
          cacsc_pkg::CACSC_SEL_TOP_STOP:
            sel_next = cacsc_pkg::CACSC_SEL_CARRYUP;
          default:
          begin
            sel_next = cacsc_pkg::CACSC_SEL_ANGLE_SPEED;
            ts_next = ts_work_reg;
            cu_next = cu_work_reg;
            commit_next = 1'b1;
          end
        endcase
      end
      else if (sel_reg == cacsc_pkg::CACSC_SEL_TOP_STOP)
      begin
        if (plus_rise_c)
          ts_work_next = ang_inc(ts_work_reg);
        else if (minus_rise_c)
          ts_work_next = ang_dec(ts_work_reg);
      end
      else if (sel_reg == cacsc_pkg::CACSC_SEL_CARRYUP
               && !opt_reg[cacsc_pkg::OPT_SW7])
      begin
        if (plus_rise_c)
          cu_work_next = ang_inc(cu_work_reg);
        else if (minus_rise_c)
          cu_work_next = ang_dec(cu_work_reg);
      end
    end

    win_next = win_c;
    // a new coincidence wins over the clearing select press
    fault_next = (win_reg && ovr_s)
                 || (fault_reg && !(sel_rise_c && inch_s));
    fault_code_next = fault_next ? cacsc_pkg::FAULT_SERIES : 8'h00;

    active_next = active_reg;
    passed_next = passed_reg;
    if (!active_reg)
    begin
      passed_next = 1'b0;
      active_next = single_s && run_req_c && opt_valid_reg;
    end
    else if (passed_reg && win_c)
    begin
      active_next = 1'b0; // stroke done at top stop
      passed_next = 1'b0;
    end
    else if (!passed_reg && !run_req_c)
      active_next = 1'b0; // released before carry-up: stop
    else if (crank_angle_i >= cu_reg && crank_angle_i < ts_reg)
      passed_next = 1'b1;
    run_next = active_next && (run_req_c || passed_next);
    test_next = crank_angle_i >= test_ang_c;

    disp_spm_next = speed_spm_i;
    case (sel_next)
      cacsc_pkg::CACSC_SEL_TOP_STOP: disp_ang_next = ts_work_next;
      cacsc_pkg::CACSC_SEL_CARRYUP: disp_ang_next = cu_work_next;
      default: disp_ang_next = crank_angle_i;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cap_cnt_reg <= 2'h0;
      opt_valid_reg <= 1'b0;
      opt_reg <= '0;
      sel_prev_reg <= 1'b0;
      plus_prev_reg <= 1'b0;
      minus_prev_reg <= 1'b0;
      sel_reg <= cacsc_pkg::CACSC_SEL_ANGLE_SPEED;
      ts_work_reg <= cacsc_pkg::TOP_STOP_RESET;
      ts_reg <= cacsc_pkg::TOP_STOP_RESET;
      cu_work_reg <= cacsc_pkg::CARRY_STD_RESET;
      cu_reg <= cacsc_pkg::CARRY_STD_RESET;
      win_reg <= 1'b0;
      fault_reg <= 1'b0;
      fault_code_reg <= 8'h00;
      active_reg <= 1'b0;
      passed_reg <= 1'b0;
      run_reg <= 1'b0;
      test_reg <= 1'b0;
      commit_reg <= 1'b0;
      disp_ang_reg <= 9'h000;
      disp_spm_reg <= 10'h000;
    end
    else
    begin
      cap_cnt_reg <= cap_cnt_next;
      opt_valid_reg <= opt_valid_next;
      opt_reg <= opt_next;
      sel_prev_reg <= sel_prev_next;
      plus_prev_reg <= plus_prev_next;
      minus_prev_reg <= minus_prev_next;
      sel_reg <= sel_next;
      ts_work_reg <= ts_work_next;
      ts_reg <= ts_next;
      cu_work_reg <= cu_work_next;
      cu_reg <= cu_next;
      win_reg <= win_next;
      fault_reg <= fault_next;
      fault_code_reg <= fault_code_next;
      active_reg <= active_next;
      passed_reg <= passed_next;
      run_reg <= run_next;
      test_reg <= test_next;
      commit_reg <= commit_next;
      disp_ang_reg <= disp_ang_next;
      disp_spm_reg <= disp_spm_next;
    end
  end

  assign top_stop_window_o = win_reg;
  assign overrun_fault_o = fault_reg;
  assign fault_code_o = fault_code_reg;
  assign clutch_run_o = run_reg;
  assign carryup_passed_o = passed_reg;
  assign overrun_test_active_o = test_reg;
  assign display_sel_o = sel_reg;
  assign display_angle_o = disp_ang_reg;
  assign display_spm_o = disp_spm_reg;
  assign commit_o = commit_reg;
  assign top_stop_angle_o = ts_reg;
  assign carryup_angle_o = cu_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence step_sel_s;
    inch_s && opt_valid_reg && sel_rise_c;
  endsequence

  sequence into_angle_speed_s;
    step_sel_s and (sel_reg == cacsc_pkg::CACSC_SEL_CARRYUP);
  endsequence

  window_open_a: assert property (
    crank_angle_i == ts_reg && $stable(ts_reg) |=> top_stop_window_o)
    else $error("window not open at top-stop angle");
  window_close_a: assert property (
    diff_c == cacsc_pkg::TOP_DWELL |=> !top_stop_window_o)
    else $error("window still open after dwell");
  fault_flag_a: assert property (
    top_stop_window_o && ovr_s |=> overrun_fault_o
      && fault_code_o == cacsc_pkg::FAULT_SERIES)
    else $error("overrun coincidence not flagged");
  carry_hold_a: assert property (
    passed_reg && active_reg && !win_c |=> clutch_run_o)
    else $error("stroke stopped after carry-up");
  foot_start_a: assert property (
    !active_reg && single_s && foot_s && opt_valid_reg |=> clutch_run_o)
    else $error("foot control did not start stroke");
  carry_default_a: assert property (
    $rose(opt_valid_reg) |-> cu_reg == ($past(lc_s)
      ? cacsc_pkg::CARRY_LC_RESET : cacsc_pkg::CARRY_STD_RESET))
    else $error("wrong carry-up default");
  carry_lock_a: assert property (
    opt_reg[cacsc_pkg::OPT_SW7] && opt_valid_reg |=> $stable(cu_work_reg))
    else $error("carry-up changed while locked");
  option_frozen_a: assert property (
    opt_valid_reg |=> $stable(opt_reg))
    else $error("option switches resampled");
  select_step_a: assert property (
    step_sel_s and (sel_reg == cacsc_pkg::CACSC_SEL_ANGLE_SPEED)
      |=> sel_reg == cacsc_pkg::CACSC_SEL_TOP_STOP)
    else $error("select did not advance");
  key_step_a: assert property (
    inch_s && opt_valid_reg && !sel_rise_c && plus_rise_c
      && sel_reg == cacsc_pkg::CACSC_SEL_TOP_STOP
      |=> ts_work_reg == ang_inc($past(ts_work_reg)))
    else $error("plus key step wrong");
  commit_store_a: assert property (
    into_angle_speed_s |=> commit_o ##0 ts_reg == ts_work_reg
      ##0 sel_reg == cacsc_pkg::CACSC_SEL_ANGLE_SPEED)
    else $error("setting not committed");
  show_angle_a: assert property (
    sel_reg == cacsc_pkg::CACSC_SEL_ANGLE_SPEED && !sel_rise_c
      |=> display_angle_o == $past(crank_angle_i)
      && display_spm_o == $past(speed_spm_i))
    else $error("angle/speed display wrong");
  test_start_a: assert property (
    crank_angle_i < test_ang_c |=> !overrun_test_active_o)
    else $error("closure test started early");
endmodule
`default_nettype wire

// File: tb/cacsc_press_model.sv
`default_nettype none
module cacsc_press_model (
  input wire logic clk_i,
  input wire logic turn_i,
  input wire logic [8:0] set_angle_i,
  input wire logic [8:0] ovr_on_i,
  output logic [8:0] crank_o,
  output logic overrun_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt_reg = 9'h000;
  // crank turns one degree a cycle, or is parked at the set angle
  always @(negedge clk_i)
  begin
    if (!turn_i)
      cnt_reg <= set_angle_i;
    else if (cnt_reg == 9'h167)
      cnt_reg <= 9'h000;
    else
      cnt_reg <= cnt_reg + 9'h001;
  end
  assign crank_o = turn_i ? cnt_reg : set_angle_i;
  // magnet holds the sensor on over 16 degrees; 9'h1f0 means no magnet
  assign overrun_o = (crank_o >= ovr_on_i) && (crank_o < ovr_on_i + 9'h010);
endmodule
`default_nettype wire

// File: tb/cacsc_top_bench.sv
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module cacsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [8:0] crank_angle_i, set_ang = 9'h000, ovr_on = 9'h1f0;
  logic [9:0] speed_spm_i = 10'h000;
  logic select_btn_i = 1'b0, key_plus_i = 1'b0, key_minus_i = 1'b0;
  logic overrun_sensor_i, palm_buttons_i = 1'b0, foot_control_i = 1'b0;
  logic inch_mode_i = 1'b0, single_mode_i = 1'b0, light_curtain_fw_i = 1'b0;
  logic [7:0] option_switch_block_i = 8'h00;
  logic turn = 1'b0;
  logic top_stop_window_o, overrun_fault_o, clutch_run_o, carryup_passed_o;
  logic overrun_test_active_o, commit_o;
  logic [7:0] fault_code_o;
  logic [1:0] display_sel_o;
  logic [8:0] display_angle_o, top_stop_angle_o, carryup_angle_o, s;
  logic [9:0] display_spm_o;
  int error_cnt = 0;
  int n_checks = 0;
  int commits = 0;

  cacsc_press_model i_cacsc_press_model (.clk_i, .turn_i(turn),
    .set_angle_i(set_ang), .ovr_on_i(ovr_on), .crank_o(crank_angle_i),
    .overrun_o(overrun_sensor_i));
  cacsc_top i_cacsc_top (.clk_i, .resetn_i, .crank_angle_i, .speed_spm_i,
    .select_btn_i, .key_plus_i, .key_minus_i, .overrun_sensor_i,
    .palm_buttons_i, .foot_control_i, .inch_mode_i, .single_mode_i,
    .light_curtain_fw_i, .option_switch_block_i, .top_stop_window_o,
    .overrun_fault_o, .fault_code_o, .clutch_run_o, .carryup_passed_o,
    .overrun_test_active_o, .display_sel_o, .display_angle_o, .display_spm_o,
    .commit_o, .top_stop_angle_o, .carryup_angle_o);

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic do_reset(input logic [7:0] opt, input logic lc);
    @(negedge clk_i);
    resetn_i = 1'b0;
    option_switch_block_i = opt;
    light_curtain_fw_i = lc;
    step(8);
    resetn_i = 1'b1;
    step(8);
  endtask

  task automatic put(input logic [8:0] a);
    @(negedge clk_i);
    set_ang = a;
    @(negedge clk_i);
  endtask

  // 0 select, 1 plus, 2 minus; five cycles held, three released
  task automatic press(input int k);
    @(negedge clk_i);
    if (k == 0)
      select_btn_i = 1'b1;
    else if (k == 1)
      key_plus_i = 1'b1;
    else
      key_minus_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_i);
      if (i == 4)
        {select_btn_i, key_plus_i, key_minus_i} = 3'b000;
      if (commit_o === 1'b1)
        commits++;
    end
  endtask

  task automatic t_options();
    for (int lc = 0; lc < 2; lc++)
    begin
      do_reset(8'h00, lc[0]);
      s = lc ? cacsc_pkg::CARRY_LC_RESET : cacsc_pkg::CARRY_STD_RESET;
      `CHK("carryup", s, carryup_angle_o);
    end
    for (int c = 0; c < 4; c++)
    begin
      case (c)
        3: s = cacsc_pkg::TEST_START_11;
        2: s = cacsc_pkg::TEST_START_10;
        1: s = cacsc_pkg::TEST_START_01;
        default: s = cacsc_pkg::TEST_START_00;
      endcase
      do_reset({6'h00, c[0], c[1]}, 1'b0);
      put(s - 9'h001);
      `CHK("test_lo", 1'b0, overrun_test_active_o);
      put(s);
      `CHK("test_hi", 1'b1, overrun_test_active_o);
    end
    $display("test options done");
  endtask

  task automatic t_window();
    s = cacsc_pkg::TOP_STOP_RESET;
    put(s - 9'h001);
    `CHK("win_pre", 1'b0, top_stop_window_o);
    put(s);
    `CHK("win_on", 1'b1, top_stop_window_o);
    put(s + 9'h013);
    `CHK("win_last", 1'b1, top_stop_window_o);
    put(s + 9'h014);
    `CHK("win_off", 1'b0, top_stop_window_o);
    $display("test window done");
  endtask

  task automatic t_panel();
    inch_mode_i = 1'b1;
    press(0);
    `CHK("sel_ts", 2'b01, display_sel_o);
    press(1);
    `CHK("ts_up", 9'h0d4, display_angle_o);
    press(2);
    press(2);
    `CHK("ts_dn", 9'h0d2, display_angle_o);
    press(0);
    `CHK("sel_cu", 2'b10, display_sel_o);
    repeat (171) press(2);
    `CHK("cu_wrap", cacsc_pkg::ANGLE_MAX, display_angle_o);
    press(1);
    `CHK("cu_wrap0", 9'h000, display_angle_o);
    `CHK("no_early", 0, commits);
    press(0);
    `CHK("commit", 1, commits);
    `CHK("ts_kept", 9'h0d2, top_stop_angle_o);
    `CHK("cu_kept", 9'h000, carryup_angle_o);
    speed_spm_i = 10'h03c;
    put(9'h05a);
    step(1);
    `CHK("disp_ang", 9'h05a, display_angle_o);
    `CHK("disp_spm", 10'h03c, display_spm_o);
    put(9'h0d7);
    ovr_on = 9'h0d2;
    step(5);
    `CHK("fault", 1'b1, overrun_fault_o);
    `CHK("fcode", cacsc_pkg::FAULT_SERIES, fault_code_o);
    ovr_on = 9'h1f0;
    press(0);
    `CHK("fclear", 1'b0, overrun_fault_o);
    $display("test panel done");
  endtask

  task automatic t_lock();
    do_reset(8'h40, 1'b0);
    inch_mode_i = 1'b1;
    press(0);
    press(0);
    press(1);
    `CHK("cu_lock", cacsc_pkg::CARRY_STD_RESET, display_angle_o);
    option_switch_block_i = 8'h00;
    press(1);
    `CHK("cu_once", cacsc_pkg::CARRY_STD_RESET, display_angle_o);
    press(0);
    `CHK("cu_stay", cacsc_pkg::CARRY_STD_RESET, carryup_angle_o);
    inch_mode_i = 1'b0;
    $display("test lock done");
  endtask

  task automatic t_stroke();
    single_mode_i = 1'b1;
    put(9'h064);
    palm_buttons_i = 1'b1;
    step(4);
    `CHK("run", 1'b1, clutch_run_o);
    palm_buttons_i = 1'b0;
    step(4);
    `CHK("early_rel", 1'b0, clutch_run_o);
    for (int k = 0; k < 2; k++)
    begin
      put(9'h0a0);
      {foot_control_i, palm_buttons_i} = k ? 2'b10 : 2'b01;
      step(4);
      turn = 1'b1;
      step(20);
      {foot_control_i, palm_buttons_i} = 2'b00;
      step(3);
      `CHK("passed", 1'b1, carryup_passed_o);
      `CHK("carry", 1'b1, clutch_run_o);
      step(35);
      `CHK("stroke_end", 1'b0, clutch_run_o);
      turn = 1'b0;
    end
    $display("test stroke done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    step(10000);
    error_cnt++;
    conclude();
  end

  initial
  begin
    do_reset(8'h00, 1'b0);
    t_options();
    do_reset(8'h00, 1'b0);
    t_window();
    t_panel();
    t_lock();
    t_stroke();
    conclude();
  end
endmodule
`default_nettype wire
